// File: tt_pkg.sv
// tt_pkg: constants shared by the transmit config and status block
package tt_pkg;

   // ==========================================
   // register offsets
   localparam logic [15:0] TT_TX_IO_CONFIG_OFS         = 16'h0184;
   localparam logic [15:0] TT_TX_ALARM_CODE_CONTROL_OFS = 16'h0186;
   localparam logic [15:0] TT_TX_LATCHED_STATUS_OFS    = 16'h0190;
   localparam logic [15:0] TT_TX_INTERRUPT_MASK_OFS    = 16'h01a0;
   localparam logic [15:0] TT_CHAN_LOOPBACK_LOW_OFS    = 16'h01d0;
   localparam logic [15:0] TT_CHAN_LOOPBACK_MID_OFS    = 16'h01d1;
   localparam logic [15:0] TT_CHAN_LOOPBACK_HIGH_OFS   = 16'h01d2;
   localparam logic [7:0]  TT_REG_RESET                = 8'h00;
   localparam logic [7:0]  TT_UNMAPPED_READ            = 8'h00;

   // ==========================================
   // tx_io_config fields
   localparam int TT_IO_CLOCK_INVERT  = 7;
   localparam int TT_IO_SYNC_INVERT   = 6;
   localparam int TT_IO_BP_SYNC_INV   = 5;
   localparam int TT_IO_BP_RATE_SEL   = 4;
   localparam int TT_IO_BP_SYNC_MODE  = 3;
   localparam int TT_IO_SYNC_DIR      = 2;
   localparam int TT_IO_SYNC_DW       = 1;
   localparam int TT_IO_SYNC_MODE     = 0;

   // ==========================================
   // tx_alarm_code_control fields
   localparam int TT_AC_RAI_PAT_SEL   = 3;
   localparam int TT_AC_AIS_PAT_SEL   = 2;
   localparam int TT_AC_LEN_MSB       = 1;
   localparam int TT_AC_LEN_LSB       = 0;
   localparam int TT_AC_USED_BITS     = 4;

   // ==========================================
   // latched status / mask fields
   localparam int TT_ST_CLOCK_LOSS    = 0;
   localparam int TT_ST_CLOCK_CLEARED = 1;
   localparam int TT_ST_MULTIFRAME    = 2;
   localparam int TT_ST_DENSITY       = 3;
   localparam int TT_ST_SLC_MF        = 4;
   localparam int TT_ST_BITS          = 5;

   // ==========================================
   // frame structure
   localparam int TT_FRAME_BITS       = 193;
   localparam int TT_CHANNELS         = 24;
   localparam int TT_ESF_FRAMES       = 24;
   localparam int TT_D4_FRAMES        = 12;
   localparam int TT_SIG_FRAME_STEP   = 6;
   localparam int TT_SLC_FRAMES       = 72;
   localparam int TT_MAX_ZERO_RUN     = 15;
   localparam int TT_RAI_D4_BIT       = 1;
   localparam logic [15:0] TT_RAI_PATTERN    = 16'hff00;
   localparam logic [15:0] TT_RAI_CI_PATTERN = 16'hfe00;
   localparam logic [7:0]  TT_AIS_CI_BYTE    = 8'h7c;

   // ==========================================
   // loop code lengths, in bits
   localparam logic [4:0] TT_LEN_CODE0 = 5'h05;
   localparam logic [4:0] TT_LEN_CODE1 = 5'h06;
   localparam logic [4:0] TT_LEN_CODE2 = 5'h07;
   localparam logic [4:0] TT_LEN_CODE3 = 5'h10;

   // ==========================================
   // timing
   localparam int TT_SYS_PERIOD_NS    = 100;
   localparam int TT_TXCLK_PERIOD_NS  = 800;
   localparam int TT_LOSS_PERIODS     = 3;
   localparam int TT_LOSS_CYCLES      =
      (TT_LOSS_PERIODS * TT_TXCLK_PERIOD_NS + TT_SYS_PERIOD_NS - 1) / TT_SYS_PERIOD_NS;

endpackage

// File: tt_sync.sv
// tt_sync: two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module tt_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_q
);
   logic [WIDTH-1:0] meta_q;

   initial begin
      if (WIDTH < 1) begin
         $error("tt_sync: WIDTH must be at least 1");
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce) begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
endmodule

// File: tt_clk_watch.sv
// tt_clk_watch: samples the transmit clock pin, finds edges, watches for loss
`timescale 1ns/10ps
module tt_clk_watch
   import tt_pkg::*;
#(
   parameter int LOSS_CYCLES = TT_LOSS_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic clk_pin,
   input  wire logic invert,
   output logic      rise_q,
   output logic      loss_q,
   output logic      regain_q
);
   localparam int CW = $clog2(LOSS_CYCLES + 1);
   localparam logic [CW-1:0] LIMIT = CW'(LOSS_CYCLES);

   logic          meta_q;
   logic          lvl_q;
   logic          prev_q;
   logic [CW-1:0] idle_q;
   logic          used;

   initial begin
      if (LOSS_CYCLES < 2) begin
         $error("tt_clk_watch: LOSS_CYCLES must be at least 2");
      end
   end

   // ==========================================
   // synchroniser and edge finding
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_q <= 1'b0;
         lvl_q  <= 1'b0;
      end else if (ce) begin
         meta_q <= clk_pin;
         lvl_q  <= meta_q;
      end
   end

   assign used = lvl_q ^ invert;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prev_q <= 1'b0;
         rise_q <= 1'b0;
      end else if (ce) begin
         prev_q <= used;
         rise_q <= used & ~prev_q;
      end
   end

   // ==========================================
   // loss detection: any transition restarts the idle count
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         idle_q   <= '0;
         loss_q   <= 1'b0;
         regain_q <= 1'b0;
      end else if (ce) begin
         regain_q <= 1'b0;
         if (used != prev_q) begin
            idle_q <= '0;
            if (loss_q) begin
               loss_q   <= 1'b0;
               regain_q <= 1'b1;
            end
         end else if (idle_q != LIMIT) begin
            idle_q <= idle_q + CW'(1);
         end else begin
            loss_q <= 1'b1;
         end
      end
   end
endmodule

// File: tt_tx_ctrl.sv
// tt_tx_ctrl: transmit config, status, interrupt and per-channel loopback
`timescale 1ns/10ps
module tt_tx_ctrl
   import tt_pkg::*;
#(
   parameter int LOSS_CYCLES = TT_LOSS_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        host_sel,
   input  wire logic        host_wr,
   input  wire logic        host_rd,
   input  wire logic [15:0] host_addr,
   input  wire logic [7:0]  host_wdata,
   output logic      [7:0]  host_rdata_q,
   output logic             int_n_q,
   input  wire logic        remote_alarm_enable,
   input  wire logic        alarm_ind_enable,
   input  wire logic        tx_frame_mode,
   input  wire logic        slc_insert_enable,
   input  wire logic        clock_loss_pin_enable,
   input  wire logic        tx_clock_in,
   input  wire logic        backplane_sync,
   input  wire logic        tx_frame_sync_in,
   output logic             tx_frame_sync_out_q,
   output logic             tx_frame_sync_oe_q,
   input  wire logic        tx_serial_data,
   input  wire logic        rx_loop_data,
   output logic             tx_line_data_q,
   output logic             tx_clock_loss_pin_q,
   output logic             backplane_rate_sel_q,
   output logic      [4:0]  loop_code_bits_q,
   output logic      [7:0]  rt_status_q
);
   initial begin
      if (LOSS_CYCLES < 2) begin
         $error("tt_tx_ctrl: LOSS_CYCLES must be at least 2");
      end
   end

   // ==========================================
   // helpers
   function automatic logic [4:0] code_len(input logic [1:0] sel);
      case (sel)
         2'h0:    code_len = TT_LEN_CODE0;
         2'h1:    code_len = TT_LEN_CODE1;
         2'h2:    code_len = TT_LEN_CODE2;
         default: code_len = TT_LEN_CODE3;
      endcase
   endfunction

   function automatic logic is_sig_frame(input logic [4:0] frame);
      is_sig_frame = (5'(frame % 5'(TT_SIG_FRAME_STEP)) == 5'(TT_SIG_FRAME_STEP - 1));
   endfunction

   // ==========================================
   // registers
   logic [7:0]          io_cfg_q;
   logic [7:0]          alarm_ctl_q;
   logic [7:0]          status_q;
   logic [7:0]          mask_q;
   logic [23:0]         loop_en_q;
   logic                wr_hit;
   logic [TT_ST_BITS-1:0] ev;

   assign wr_hit = host_sel & host_wr;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         io_cfg_q    <= TT_REG_RESET;
         alarm_ctl_q <= TT_REG_RESET;
         mask_q      <= TT_REG_RESET;
         loop_en_q   <= {3{TT_REG_RESET}};
      end else if (ce && wr_hit) begin
         case (host_addr)
            TT_TX_IO_CONFIG_OFS:          io_cfg_q <= host_wdata;
            TT_TX_ALARM_CODE_CONTROL_OFS: alarm_ctl_q <= host_wdata;
            TT_TX_INTERRUPT_MASK_OFS:     mask_q <= host_wdata;
            TT_CHAN_LOOPBACK_LOW_OFS:     loop_en_q[7:0] <= host_wdata;
            TT_CHAN_LOOPBACK_MID_OFS:     loop_en_q[15:8] <= host_wdata;
            TT_CHAN_LOOPBACK_HIGH_OFS:    loop_en_q[23:16] <= host_wdata;
            default: ;
         endcase
      end
   end

   // latched status: a new event wins over a same-cycle clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         status_q <= TT_REG_RESET;
      end else if (ce) begin
         for (int i = 0; i < TT_ST_BITS; i++) begin
            if (ev[i]) begin
               status_q[i] <= 1'b1;
            end else if (wr_hit && host_addr == TT_TX_LATCHED_STATUS_OFS && host_wdata[i]) begin
               status_q[i] <= 1'b0;
            end
         end
      end
   end

   // read data registered; reads have no side effects
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         host_rdata_q <= TT_REG_RESET;
      end else if (ce && host_sel && host_rd) begin
         case (host_addr)
            TT_TX_IO_CONFIG_OFS:          host_rdata_q <= io_cfg_q;
            TT_TX_ALARM_CODE_CONTROL_OFS: host_rdata_q <= alarm_ctl_q;
            TT_TX_LATCHED_STATUS_OFS:     host_rdata_q <= status_q;
            TT_TX_INTERRUPT_MASK_OFS:     host_rdata_q <= mask_q;
            TT_CHAN_LOOPBACK_LOW_OFS:     host_rdata_q <= loop_en_q[7:0];
            TT_CHAN_LOOPBACK_MID_OFS:     host_rdata_q <= loop_en_q[15:8];
            TT_CHAN_LOOPBACK_HIGH_OFS:    host_rdata_q <= loop_en_q[23:16];
            default:                      host_rdata_q <= TT_UNMAPPED_READ;
         endcase
      end
   end

   // ==========================================
   // pin inputs
   logic       rise;
   logic       loss;
   logic       regain;
   logic [3:0] pins_s;
   logic       sync_in;
   logic       bp_sync;
   logic       ser_in;
   logic       rx_in;

   tt_clk_watch #(
      .LOSS_CYCLES (LOSS_CYCLES)
   ) u_clk_watch (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .ce       (ce),
      .clk_pin  (tx_clock_in),
      .invert   (io_cfg_q[TT_IO_CLOCK_INVERT]),
      .rise_q   (rise),
      .loss_q   (loss),
      .regain_q (regain)
   );

   tt_sync #(
      .WIDTH (4)
   ) u_pin_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .ce       (ce),
      .async_in ({tx_frame_sync_in, backplane_sync, tx_serial_data, rx_loop_data}),
      .sync_q   (pins_s)
   );

   assign sync_in = pins_s[3] ^ io_cfg_q[TT_IO_SYNC_INVERT];
   assign bp_sync = pins_s[2] ^ io_cfg_q[TT_IO_BP_SYNC_INV];
   assign ser_in  = pins_s[1];
   assign rx_in   = pins_s[0];

   // ==========================================
   // frame alignment and counters
   logic [7:0] bit_q;
   logic [4:0] frame_q;
   logic [6:0] slc_q;
   logic       sync_prev_q;
   logic       bp_prev_q;
   logic       align_q;
   logic       align_mf_q;
   logic [4:0] mf_last;
   logic       frame_end;
   logic       mf_end;
   logic       use_sync_pin;

   assign mf_last      = tx_frame_mode ? 5'(TT_D4_FRAMES - 1) : 5'(TT_ESF_FRAMES - 1);
   assign frame_end    = (bit_q == 8'(TT_FRAME_BITS - 1));
   assign mf_end       = frame_end && (frame_q >= mf_last);
   assign use_sync_pin = ~io_cfg_q[TT_IO_SYNC_DIR];

   // a sync edge is held until the next bit so it lands on a clean boundary
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync_prev_q <= 1'b0;
         bp_prev_q   <= 1'b0;
         align_q     <= 1'b0;
         align_mf_q  <= 1'b0;
      end else if (ce) begin
         sync_prev_q <= sync_in;
         bp_prev_q   <= bp_sync;
         if (use_sync_pin && sync_in && !sync_prev_q) begin
            align_q    <= 1'b1;
            align_mf_q <= 1'b0;
         end else if (!use_sync_pin && bp_sync && !bp_prev_q) begin
            align_q    <= 1'b1;
            align_mf_q <= io_cfg_q[TT_IO_BP_SYNC_MODE];
         end else if (rise) begin
            align_q    <= 1'b0;
            align_mf_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bit_q   <= '0;
         frame_q <= '0;
      end else if (ce && rise) begin
         if (align_q) begin
            bit_q <= '0;
            if (align_mf_q || mf_end) begin
               frame_q <= '0;
            end else if (frame_end) begin
               frame_q <= frame_q + 5'h01;
            end
         end else if (frame_end) begin
            bit_q   <= '0;
            frame_q <= mf_end ? 5'h00 : frame_q + 5'h01;
         end else begin
            bit_q <= bit_q + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         slc_q <= '0;
      end else if (ce && rise && frame_end) begin
         if (!slc_insert_enable || slc_q == 7'(TT_SLC_FRAMES - 1)) begin
            slc_q <= '0;
         end else begin
            slc_q <= slc_q + 7'h01;
         end
      end
   end

   // ==========================================
   // sync output
   logic sync_pulse;

   always_comb begin
      if (io_cfg_q[TT_IO_SYNC_MODE]) begin
         sync_pulse = (bit_q == 8'h00) && (frame_q == 5'h00);
      end else begin
         sync_pulse = (bit_q == 8'h00) ||
                      (io_cfg_q[TT_IO_SYNC_DW] && bit_q == 8'h01 && is_sig_frame(frame_q));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_frame_sync_out_q <= 1'b0;
         tx_frame_sync_oe_q  <= 1'b0;
      end else if (ce) begin
         tx_frame_sync_oe_q  <= io_cfg_q[TT_IO_SYNC_DIR];
         tx_frame_sync_out_q <= sync_pulse ^ io_cfg_q[TT_IO_SYNC_INVERT];
      end
   end

   // ==========================================
   // outgoing data
   logic [4:0]  chan;
   logic [2:0]  bit_in_chan;
   logic [3:0]  fdl_q;
   logic        out_bit;
   logic [15:0] rai_pat;

   assign chan        = 5'((bit_q - 8'h01) >> 3);
   assign bit_in_chan = 3'(bit_q - 8'h01);
   assign rai_pat     = alarm_ctl_q[TT_AC_RAI_PAT_SEL] ? TT_RAI_CI_PATTERN : TT_RAI_PATTERN;

   always_comb begin
      if (bit_q != 8'h00 && loop_en_q[chan]) begin
         out_bit = rx_in;
      end else begin
         out_bit = ser_in;
      end
      if (alarm_ind_enable) begin
         if (alarm_ctl_q[TT_AC_AIS_PAT_SEL] && bit_q != 8'h00 && chan == 5'(TT_CHANNELS - 1)) begin
            out_bit = TT_AIS_CI_BYTE[3'h7 - bit_in_chan];
         end else begin
            out_bit = 1'b1;
         end
      end else if (remote_alarm_enable && !tx_frame_mode) begin
         if (bit_q == 8'h00 && !frame_q[0]) begin
            out_bit = rai_pat[4'hf - fdl_q];
         end
      end else if (remote_alarm_enable && bit_q != 8'h00 && bit_in_chan == 3'(TT_RAI_D4_BIT)) begin
         out_bit = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_line_data_q <= 1'b0;
         fdl_q          <= '0;
      end else if (ce && rise) begin
         tx_line_data_q <= out_bit;
         if (bit_q == 8'h00 && !frame_q[0]) begin
            fdl_q <= fdl_q + 4'h1;
         end
      end
   end

   // ==========================================
   // density watch: zeros counted on what leaves the block
   logic [3:0] zero_run_q;
   logic       density_ev;

   assign density_ev = rise && !out_bit && zero_run_q == 4'(TT_MAX_ZERO_RUN);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         zero_run_q <= '0;
      end else if (ce && rise) begin
         if (out_bit) begin
            zero_run_q <= '0;
         end else if (zero_run_q != 4'(TT_MAX_ZERO_RUN)) begin
            zero_run_q <= zero_run_q + 4'h1;
         end
      end
   end

   // ==========================================
   // events, interrupt and plain outputs
   logic loss_prev_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         loss_prev_q <= 1'b0;
      end else if (ce) begin
         loss_prev_q <= loss;
      end
   end

   always_comb begin
      ev                      = '0;
      ev[TT_ST_CLOCK_LOSS]    = loss & ~loss_prev_q;
      ev[TT_ST_CLOCK_CLEARED] = regain;
      ev[TT_ST_MULTIFRAME]    = rise & mf_end;
      ev[TT_ST_DENSITY]       = density_ev;
      ev[TT_ST_SLC_MF]        = rise & frame_end & slc_insert_enable &
                                (slc_q == 7'(TT_SLC_FRAMES - 1));
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         int_n_q              <= 1'b1;
         tx_clock_loss_pin_q  <= 1'b0;
         backplane_rate_sel_q <= 1'b0;
         loop_code_bits_q     <= TT_LEN_CODE0;
         rt_status_q          <= TT_REG_RESET;
      end else if (ce) begin
         int_n_q              <= ~|(status_q & mask_q);
         tx_clock_loss_pin_q  <= loss & clock_loss_pin_enable;
         backplane_rate_sel_q <= io_cfg_q[TT_IO_BP_RATE_SEL];
         loop_code_bits_q     <= code_len(alarm_ctl_q[TT_AC_LEN_MSB:TT_AC_LEN_LSB]);
         rt_status_q          <= {7'h00, loss};
      end
   end
endmodule

// File: tt_tx_ctrl_properties.sv
// tt_tx_ctrl_properties: port-level assertions for the transmit control block
`timescale 1ns/10ps
module tt_tx_ctrl_props
   import tt_pkg::*;
#(
   parameter int LOSS_CYCLES = 24
) (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        host_sel,
   input wire logic        host_wr,
   input wire logic        host_rd,
   input wire logic [15:0] host_addr,
   input wire logic [7:0]  host_wdata,
   input wire logic [7:0]  host_rdata_q,
   input wire logic        int_n_q,
   input wire logic        clock_loss_pin_enable,
   input wire logic        tx_frame_sync_oe_q,
   input wire logic        tx_line_data_q,
   input wire logic        tx_clock_loss_pin_q,
   input wire logic        backplane_rate_sel_q,
   input wire logic [4:0]  loop_code_bits_q,
   input wire logic [7:0]  rt_status_q
);
   // ==========================================
   // helpers and sequences
   wire st_wr = host_sel && host_wr &&
      (host_addr == TT_TX_LATCHED_STATUS_OFS || host_addr == TT_TX_INTERRUPT_MASK_OFS);
   function automatic logic [4:0] len_of(input logic [1:0] f);
      return f == 2'h0 ? TT_LEN_CODE0 : f == 2'h1 ? TT_LEN_CODE1 : f == 2'h2 ? TT_LEN_CODE2 : TT_LEN_CODE3;
   endfunction
   // an invert write may add one extra clock edge
   wire io_wr = host_sel && host_wr && host_addr == TT_TX_IO_CONFIG_OFS;
   logic [3:0] io_age = 4'hf;
   always @(posedge sys_clk) begin
      io_age <= io_wr ? 4'h0 : io_age + 4'(io_age != 4'hf);
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_wr_io;
      host_sel && host_wr && host_addr == TT_TX_IO_CONFIG_OFS;
   endsequence
   sequence s_wr_code;
      host_sel && host_wr && host_addr == TT_TX_ALARM_CODE_CONTROL_OFS;
   endsequence
   // ==========================================
   // assertions
   a_sync_dir_follow: assert property (s_wr_io |=> ##1 tx_frame_sync_oe_q == $past(host_wdata[2], 2))
      else $error("sync enable does not follow direction bit");
   a_rate_sel_follow: assert property (s_wr_io |=> ##1 backplane_rate_sel_q == $past(host_wdata[4], 2))
      else $error("rate select does not follow its bit");
   a_code_len_map: assert property (s_wr_code |=> ##1 loop_code_bits_q == len_of($past(host_wdata[1:0], 2)))
      else $error("loop code length wrong");
   a_rdata_hold: assert property (!(host_sel && host_rd) |=> $stable(host_rdata_q))
      else $error("read data moved without a read");
   a_int_release: assert property ($rose(int_n_q) |-> $past(st_wr) || $past(st_wr, 2) || $past(st_wr, 3))
      else $error("interrupt released without a host write");
   a_loss_pin_gate: assert property (tx_clock_loss_pin_q |-> $past(clock_loss_pin_enable))
      else $error("loss pin high while disabled");
   a_loss_pin_on: assert property ((rt_status_q[0] && clock_loss_pin_enable) [*3] |-> tx_clock_loss_pin_q)
      else $error("loss pin low during clock loss");
   a_line_bit_rate: assert property ($changed(tx_line_data_q) && !io_wr && io_age > 4'h4
      |=> $stable(tx_line_data_q) [*3])
      else $error("line data changed faster than the bit clock");
endmodule
bind tt_tx_ctrl tt_tx_ctrl_props #(.LOSS_CYCLES(LOSS_CYCLES)) i_props (.sys_clk, .rst, .host_sel, .host_wr,
   .host_rd, .host_addr, .host_wdata, .host_rdata_q, .int_n_q, .clock_loss_pin_enable, .tx_frame_sync_oe_q,
   .tx_line_data_q, .tx_clock_loss_pin_q, .backplane_rate_sel_q, .loop_code_bits_q, .rt_status_q);

// File: tt_link_model.sv
// tt_link_model: far-side transmit clock and data source
`timescale 1ns/10ps
module tt_link_model (
   input wire logic run,
   input wire logic pat,
   output logic     tx_clock_in,
   output logic     tx_serial_data,
   output logic     rx_loop_data
);
   // ==========================================
   // clock stops where it stands when run drops
   initial begin
      tx_clock_in = 1'b0;
      tx_serial_data = 1'b1;
      rx_loop_data = 1'b0;
      #37;
      forever begin
         #400;
         if (run) tx_clock_in = ~tx_clock_in;
      end
   end
   always @(negedge tx_clock_in) begin
      tx_serial_data <= pat;
      rx_loop_data <= ~pat;
   end
endmodule

// File: tb.sv
// tb: self-checking bench for the transmit control block
`timescale 1ns/10ps
module tb
   import tt_pkg::*;
();
   // ==========================================
   // stimulus, table and instances
   typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] e;} tt_row_t;
   tt_row_t rows[7] = '{'{16'h0184, 8'ha5, 8'ha5}, '{16'h0186, 8'h0e, 8'h0e}, '{16'h01a0, 8'h00, 8'h00},
      '{16'h01d0, 8'h42, 8'h42}, '{16'h01d1, 8'h24, 8'h24}, '{16'h01d2, 8'h18, 8'h18}, '{16'h0185, 8'h5a, 8'h00}};
   logic [7:0]  lens[4] = '{8'h05, 8'h06, 8'h07, 8'h10};
   logic        sys_clk = 0, rst = 1, ce = 1, host_sel = 0, host_wr = 0, host_rd = 0, run = 1, pat = 1;
   logic        remote_alarm_enable = 0, alarm_ind_enable = 0, tx_frame_mode = 0, slc_insert_enable = 0;
   logic        clock_loss_pin_enable = 0, backplane_sync = 0;
   logic [15:0] host_addr = 16'h0000;
   logic [7:0]  host_wdata = 8'h00, rd_d, host_rdata_q, rt_status_q;
   logic [4:0]  loop_code_bits_q;
   logic        int_n_q, tx_frame_sync_out_q, tx_frame_sync_oe_q, tx_line_data_q, tx_clock_loss_pin_q;
   logic        backplane_rate_sel_q, tx_clock_in, tx_serial_data, rx_loop_data;
   int          fails = 0, samples_checked = 0, k, n, t0, cyc = 0;
   // far side never drives the sync pin; it rests low
   wire         sync_pin = tx_frame_sync_oe_q ? tx_frame_sync_out_q : 1'b0;
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc++;
   tt_link_model i_link (.run, .pat, .tx_clock_in, .tx_serial_data, .rx_loop_data);
   tt_tx_ctrl #(.LOSS_CYCLES(24)) i_dut (.sys_clk, .rst, .ce, .host_sel, .host_wr, .host_rd, .host_addr,
      .host_wdata, .host_rdata_q, .int_n_q, .remote_alarm_enable, .alarm_ind_enable, .tx_frame_mode,
      .slc_insert_enable, .clock_loss_pin_enable, .tx_clock_in, .backplane_sync, .tx_frame_sync_in(sync_pin),
      .tx_frame_sync_out_q, .tx_frame_sync_oe_q, .tx_serial_data, .rx_loop_data, .tx_line_data_q,
      .tx_clock_loss_pin_q, .backplane_rate_sel_q, .loop_code_bits_q, .rt_status_q);
   // ==========================================
   // tasks
   task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      {host_sel, host_wr, host_addr, host_wdata} = {2'b11, a, d};
      @(negedge sys_clk);
      {host_sel, host_wr} = 2'b00;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      {host_sel, host_rd, host_addr} = {2'b11, a};
      @(negedge sys_clk);
      {host_sel, host_rd} = 2'b00;
      @(negedge sys_clk);
      d = host_rdata_q;
   endtask
   // polling bounded; a run-out counts as a mismatch
   task automatic wait_st(input logic [7:0] m);
      for (k = 0; k < 7000; k++) begin
         rd(16'h0190, rd_d);
         if ((rd_d & m) != 8'h00) return;
      end
      fails++;
      finish_test();
   endtask
   task automatic wait_rt(input logic v);
      for (k = 0; k < 200; k++) begin
         @(negedge sys_clk);
         if (rt_status_q[0] === v) return;
      end
      fails++;
      finish_test();
   endtask
   // longest zero run over one whole frame, after a frame to settle
   task automatic max_run(output int m);
      int c;
      c = 0;
      m = 0;
      repeat (1600) @(negedge sys_clk);
      repeat (1544) begin
         @(negedge sys_clk);
         c = tx_line_data_q === 1'b0 ? c + 1 : 0;
         if (c > m) m = c;
      end
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (6) @(negedge sys_clk);
      rst = 0;
      foreach (rows[i]) begin
         rd(rows[i].a, rd_d);
         chk8("reset value", 8'h00, rd_d);
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rd_d);
         chk8("readback", rows[i].e, rd_d);
      end
      chk8("sync enable", 8'h01, {7'h0, tx_frame_sync_oe_q});
      chk8("rate select", 8'h00, {7'h0, backplane_rate_sel_q});
      wr(16'h0184, 8'h10);
      repeat (3) @(negedge sys_clk);
      chk8("sync enable", 8'h00, {7'h0, tx_frame_sync_oe_q});
      chk8("rate select", 8'h01, {7'h0, backplane_rate_sel_q});
      for (int j = 0; j < 4; j++) begin
         wr(16'h0186, j[7:0]);
         repeat (2) @(negedge sys_clk);
         chk8("code length", lens[j], {3'h0, loop_code_bits_q});
      end
      wr(16'h0184, 8'h04);
      n = 0;
      repeat (1544) begin
         @(negedge sys_clk);
         n += tx_frame_sync_out_q;
      end
      chk8("sync pulse", 8'h08, n[7:0]);
      $display("registers done");
      wr(16'h01d0, 8'h00); wr(16'h01d1, 8'h00); wr(16'h01d2, 8'h00); wr(16'h0184, 8'h00);
      for (int j = 0; j < 3; j++) begin
         wr(16'h01d0 + j[15:0], 8'h02);
         max_run(n);
         chk8("loop run", 8'h40, n[7:0]);
         wr(16'h01d0 + j[15:0], 8'h00);
      end
      wr(16'h01d0, 8'h02);
      alarm_ind_enable = 1;
      max_run(n);
      chk8("ais run", 8'h00, n[7:0]);
      wr(16'h0186, 8'h04);
      max_run(n);
      chk8("ais-ci zeros", 8'h10, n[7:0]);
      alarm_ind_enable = 0;
      wr(16'h0186, 8'h00); wr(16'h01d0, 8'h00);
      $display("loopback and alarm done");
      wr(16'h0190, 8'h1f);
      pat = 0;
      wait_st(8'h08);
      pat = 1;
      chk8("masked int", 8'h01, {7'h0, int_n_q});
      wr(16'h01a0, 8'h08);
      repeat (3) @(negedge sys_clk);
      chk8("int asserted", 8'h00, {7'h0, int_n_q});
      wr(16'h0190, 8'h00);
      rd(16'h0190, rd_d);
      chk8("kept bit", 8'h08, rd_d & 8'h08);
      repeat (200) @(negedge sys_clk);
      wr(16'h0190, 8'h08);
      rd(16'h0190, rd_d);
      chk8("cleared bit", 8'h00, rd_d & 8'h08);
      chk8("int released", 8'h01, {7'h0, int_n_q});
      wr(16'h01a0, 8'h00); wr(16'h0190, 8'h1f);
      clock_loss_pin_enable = 1;
      run = 0;
      wait_rt(1'b1);
      repeat (3) @(negedge sys_clk);
      chk8("loss pin", 8'h01, {7'h0, tx_clock_loss_pin_q});
      wr(16'h0190, 8'h01);
      rd(16'h0190, rd_d);
      chk8("loss bit cleared", 8'h00, rd_d & 8'h01);
      chk8("pin held", 8'h01, {7'h0, tx_clock_loss_pin_q});
      run = 1;
      wait_rt(1'b0);
      rd(16'h0190, rd_d);
      chk8("regain bit", 8'h02, rd_d & 8'h02);
      chk8("pin off", 8'h00, {7'h0, tx_clock_loss_pin_q});
      $display("status done");
      tx_frame_mode = 1;
      wait_st(8'h04);
      wr(16'h0190, 8'h04);
      wait_st(8'h04);
      t0 = cyc;
      wr(16'h0190, 8'h04);
      wait_st(8'h04);
      n = cyc - t0;
      chk8("mf period", 8'h01, {7'h0, n > 18520 && n < 18540});
      remote_alarm_enable = 1;
      max_run(n);
      chk8("d4 rai run", 8'h08, n[7:0]);
      $display("multiframe done");
      finish_test();
   end
endmodule
